//--- design/lpi_device.sv
// Memory device end: command decode, banks, mode registers, masked write and strobed read bursts
`timescale 1ns/10ps
`default_nettype none
`include "lpi_map.svh"

module lpi_device (
  // Local clock and reset
  input  wire logic                  mclk,
  input  wire logic                  srst,
  // Link
  lpi_link_if.dev                    link,
  // Status toward local logic
  output var  logic [`LPI_BANKS-1:0] bank_open
);

  logic [3:0]                 hold_q;
  logic                       rst_req_q;
  logic [1:0]                 rst_sync_q;
  logic                       lrst;
  logic [3:0]                 cmd_bits;
  logic                       cmd_live;
  logic                       do_lmr;
  logic                       do_act;
  logic                       do_pre;
  logic                       do_wr;
  logic                       do_rd;
  logic [`LPI_ADDR_W-1:0]     mode_q [`LPI_BANKS];
  logic [3:0]                 burst_last;
  logic [`LPI_BANKS-1:0]      open_q;
  logic [`LPI_ADDR_W-1:0]     row_q [`LPI_BANKS];
  lpi_pkg::lpi_dev_state_t    state_q;
  logic [3:0]                 beat_q;
  logic [1:0]                 bank_q;
  logic [3:0]                 col_q;
  logic                       ap_q;
  logic [`LPI_LANES-1:0]      dqs_prev_q;
  logic [`LPI_LANES-1:0]      lane_edge;
  logic                       wr_phase;
  logic                       burst_end;
  logic [7:0]                 mem_idx;
  logic [3:0]                 cur_col;
  logic [`LPI_DQ_W-1:0]       rd_word;
  logic [`LPI_DQ_W-1:0]       dq_q;
  logic                       dq_oe_q;
  logic [`LPI_LANES-1:0]      dqs_q;
  logic                       dqs_oe_q;
  logic [`LPI_BANKS-1:0]      open_s1_q;

  // Reset stretched past srst: the link clock stands still while srst is high
  always_ff @(posedge mclk) begin
    if (srst) begin
      hold_q    <= `LPI_RST_HOLD;
      rst_req_q <= 1'b1;
    end else begin
      hold_q    <= (hold_q == 4'h0) ? 4'h0 : hold_q - 4'h1;
      rst_req_q <= (hold_q != 4'h0);
    end
  end

  // Reset brought into the link clock domain
  always_ff @(posedge link.link_clk) begin
    rst_sync_q <= {rst_sync_q[0], rst_req_q};
  end
  assign lrst = rst_sync_q[1];

  // Command decode on each rising link edge
  assign cmd_bits = {link.cs_n, link.ras_n, link.cas_n, link.we_n};
  assign cmd_live = !link.cs_n && (state_q == lpi_pkg::dev_idle);
  assign do_lmr   = cmd_live && (cmd_bits == lpi_pkg::cmd_lmr);
  assign do_act   = cmd_live && (cmd_bits == lpi_pkg::cmd_act);
  assign do_pre   = cmd_live && (cmd_bits == lpi_pkg::cmd_pre);
  assign do_wr    = cmd_live && (cmd_bits == lpi_pkg::cmd_wr);
  assign do_rd    = cmd_live && (cmd_bits == lpi_pkg::cmd_rd);

  // Mode registers
  always_ff @(posedge link.link_clk) begin
    if (lrst) begin
      for (int i = 0; i < `LPI_BANKS; i++) begin
        mode_q[i] <= `LPI_MR_RESET;
      end
    end else if (do_lmr) begin
      mode_q[link.bank_select] <= link.addr;
    end
  end

  assign burst_last = lpi_pkg::lpi_burst_last(mode_q[0][`LPI_BL_MSB:`LPI_BL_LSB]);

  // Write strobe edges per lane; undriven strobe rests low
  assign lane_edge = link.dqs ^ dqs_prev_q;
  assign wr_phase  = (state_q == lpi_pkg::dev_write);
  assign burst_end = (wr_phase && lane_edge[0] && beat_q == burst_last)
                   || (state_q == lpi_pkg::dev_read_end);

  always_ff @(posedge link.link_clk) begin
    if (lrst) begin
      dqs_prev_q <= '0;
    end else begin
      dqs_prev_q <= link.dqs;
    end
  end

  // Bank open state and open row
  always_ff @(posedge link.link_clk) begin
    if (lrst) begin
      open_q <= '0;
      for (int i = 0; i < `LPI_BANKS; i++) begin
        row_q[i] <= '0;
      end
    end else if (do_act) begin
      open_q[link.bank_select] <= 1'b1;
      row_q[link.bank_select]  <= link.addr;
    end else if (do_pre) begin
      if (link.addr[`LPI_AUTO_CLOSE_BIT]) begin
        open_q <= '0;
      end else begin
        open_q[link.bank_select] <= 1'b0;
      end
    end else if (burst_end && ap_q) begin
      open_q[bank_q] <= 1'b0;
    end
  end

  // Burst sequencing
  always_ff @(posedge link.link_clk) begin
    if (lrst) begin
      state_q <= lpi_pkg::dev_idle;
      beat_q  <= 4'h0;
      bank_q  <= 2'h0;
      col_q   <= 4'h0;
      ap_q    <= 1'b0;
    end else begin
      case (state_q)
        lpi_pkg::dev_idle: begin
          beat_q <= 4'h0;
          if (do_wr || do_rd) begin
            state_q <= do_wr ? lpi_pkg::dev_write : lpi_pkg::dev_read;
            bank_q  <= link.bank_select;
            col_q   <= link.addr[3:0];
            ap_q    <= link.addr[`LPI_AUTO_CLOSE_BIT];
          end
        end
        lpi_pkg::dev_write: begin
          if (lane_edge[0]) begin
            beat_q <= beat_q + 4'h1;
            if (beat_q == burst_last) begin
              state_q <= lpi_pkg::dev_idle;
            end
          end
        end
        lpi_pkg::dev_read: begin
          beat_q <= beat_q + 4'h1;
          if (beat_q == burst_last) begin
            state_q <= lpi_pkg::dev_read_end;
          end
        end
        lpi_pkg::dev_read_end: state_q <= lpi_pkg::dev_idle;
        default:               state_q <= lpi_pkg::dev_idle;
      endcase
    end
  end

  // Storage address: bank, low row bits of the open row, column plus beat
  assign cur_col = 4'(col_q + beat_q);
  assign mem_idx = {bank_q, row_q[bank_q][1:0], cur_col};

  for (genvar g = 0; g < `LPI_LANES; g++) begin : g_lane
    logic [`LPI_LANE_W-1:0] lane_mem [`LPI_MEM_DEPTH];
    always_ff @(posedge link.link_clk) begin
      if (wr_phase && lane_edge[g] && !link.byte_write_mask[g]) begin
        lane_mem[mem_idx] <= link.dq[`LPI_LANE_W*g +: `LPI_LANE_W];
      end
    end
    assign rd_word[`LPI_LANE_W*g +: `LPI_LANE_W] = lane_mem[mem_idx];
  end

  // Read drive: data and strobe change on the same edge
  always_ff @(posedge link.link_clk) begin
    if (lrst) begin
      dq_q     <= '0;
      dq_oe_q  <= 1'b0;
      dqs_q    <= '0;
      dqs_oe_q <= 1'b0;
    end else if (state_q == lpi_pkg::dev_read) begin
      dq_q     <= rd_word;
      dq_oe_q  <= 1'b1;
      dqs_q    <= {`LPI_LANES{~beat_q[0]}};
      dqs_oe_q <= 1'b1;
    end else begin
      dq_oe_q  <= 1'b0;
      dqs_q    <= '0;
      dqs_oe_q <= 1'b0;
    end
  end

  assign link.dq_d     = dq_q;
  assign link.dq_d_oe  = dq_oe_q;
  assign link.dqs_d    = dqs_q;
  assign link.dqs_d_oe = dqs_oe_q;

  // Bank open flags are independent levels; two-stage sync into mclk
  always_ff @(posedge mclk) begin
    if (srst) begin
      open_s1_q <= '0;
      bank_open <= '0;
    end else begin
      open_s1_q <= open_q;
      bank_open <= open_s1_q;
    end
  end

endmodule

`default_nettype wire

//--- design/lpi_host.sv
// Memory controller end: command issue, write bursts, read capture, link clock divider
`timescale 1ns/10ps
`default_nettype none
`include "lpi_map.svh"

module lpi_host (
  // Local clock and reset
  input  wire logic                   mclk,
  input  wire logic                   srst,
  // Command request
  input  wire logic                   req_valid,
  output var  logic                   req_ready,
  input  wire lpi_pkg::lpi_cmd_t      req_cmd,
  input  wire logic [1:0]             req_bank,
  input  wire logic [`LPI_ADDR_W-1:0] req_addr,
  // Write beats
  input  wire logic                   wr_valid,
  output var  logic                   wr_ready,
  input  wire logic [`LPI_DQ_W-1:0]   wr_data,
  input  wire logic [`LPI_LANES-1:0]  wr_mask,
  // Read beats
  output var  logic                   rd_valid,
  output var  logic [`LPI_DQ_W-1:0]   rd_data,
  // Link
  lpi_link_if.host                    link
);

  logic [1:0]                ph_q;
  logic                      clk_q;
  lpi_pkg::lpi_host_state_t  state_q;
  logic [3:0]                beat_q;
  logic [3:0]                last_q;
  logic                      done_q;
  logic                      pend_q;
  logic [3:0]                cmd_q;
  logic [1:0]                bank_q;
  logic [`LPI_ADDR_W-1:0]    addr_q;
  logic [`LPI_DQ_W-1:0]      dq_q;
  logic [`LPI_LANES-1:0]     mask_q;
  logic                      dq_oe_q;
  logic [`LPI_LANES-1:0]     dqs_q;
  logic                      dqs_oe_q;
  logic [`LPI_DQ_W-1:0]      dq_s1_q;
  logic [`LPI_DQ_W-1:0]      dq_s2_q;
  logic                      dqs_s1_q;
  logic                      dqs_s2_q;
  logic                      dqs_s3_q;
  logic                      edge_q;
  logic                      slot;
  logic                      req_take;
  logic                      wr_take;

  assign slot     = (ph_q == `LPI_PH_SLOT);
  assign req_take = slot && req_ready && req_valid;
  assign wr_take  = slot && wr_ready && wr_valid;

  // Link clock is mclk divided by four; falls at the slot, rises one phase after the strobe toggle
  always_ff @(posedge mclk) begin
    if (srst) begin
      ph_q  <= `LPI_PH_RISE;
      clk_q <= 1'b0;
    end else begin
      ph_q  <= ph_q + 2'h1;
      clk_q <= (ph_q == `LPI_PH_RISE) || (ph_q == `LPI_PH_PRE);
    end
  end

  // Command pins change at the falling link edge, one link cycle per command
  always_ff @(posedge mclk) begin
    if (srst) begin
      cmd_q  <= lpi_pkg::cmd_nop;
      bank_q <= 2'h0;
      addr_q <= '0;
    end else if (slot) begin
      cmd_q  <= req_take ? req_cmd : lpi_pkg::cmd_nop;
      bank_q <= req_take ? req_bank : bank_q;
      addr_q <= req_take ? req_addr : addr_q;
    end
  end

  // Burst length tracks what was written to mode register 0
  always_ff @(posedge mclk) begin
    if (srst) begin
      last_q <= lpi_pkg::lpi_burst_last(3'(`LPI_MR_RESET));
    end else if (req_take && req_cmd == lpi_pkg::cmd_lmr && req_bank == 2'h0) begin
      last_q <= lpi_pkg::lpi_burst_last(req_addr[`LPI_BL_MSB:`LPI_BL_LSB]);
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      req_ready <= 1'b0;
      wr_ready  <= 1'b0;
    end else begin
      req_ready <= (ph_q == `LPI_PH_PRE) && (state_q == lpi_pkg::host_idle);
      wr_ready  <= (ph_q == `LPI_PH_PRE) && (state_q == lpi_pkg::host_write) && !done_q;
    end
  end

  // Data and mask at the falling edge, strobe one phase later: centre of the eye
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_q  <= lpi_pkg::host_idle;
      beat_q   <= 4'h0;
      done_q   <= 1'b0;
      pend_q   <= 1'b0;
      dq_q     <= '0;
      mask_q   <= '0;
      dq_oe_q  <= 1'b0;
      dqs_q    <= '0;
      dqs_oe_q <= 1'b0;
      rd_valid <= 1'b0;
      rd_data  <= '0;
    end else begin
      rd_valid <= 1'b0;
      case (state_q)
        lpi_pkg::host_idle: begin
          beat_q <= 4'h0;
          done_q <= 1'b0;
          if (req_take && req_cmd == lpi_pkg::cmd_wr) begin
            state_q <= lpi_pkg::host_write;
          end else if (req_take && req_cmd == lpi_pkg::cmd_rd) begin
            state_q <= lpi_pkg::host_read;
          end
        end
        lpi_pkg::host_write: begin
          if (slot && done_q) begin
            dq_oe_q  <= 1'b0;
            dqs_oe_q <= 1'b0;
            dqs_q    <= '0;
            state_q  <= lpi_pkg::host_idle;
          end else if (wr_take) begin
            dq_q     <= wr_data;
            mask_q   <= wr_mask;
            dq_oe_q  <= 1'b1;
            dqs_oe_q <= 1'b1;
            pend_q   <= 1'b1;
          end else if (ph_q == `LPI_PH_TOGGLE && pend_q) begin
            dqs_q  <= {`LPI_LANES{~beat_q[0]}};
            pend_q <= 1'b0;
            beat_q <= beat_q + 4'h1;
            done_q <= (beat_q == last_q);
          end
        end
        lpi_pkg::host_read: begin
          if (edge_q) begin
            rd_valid <= 1'b1;
            rd_data  <= dq_s2_q;
            beat_q   <= beat_q + 4'h1;
            if (beat_q == last_q) begin
              state_q <= lpi_pkg::host_idle;
            end
          end
        end
        default: state_q <= lpi_pkg::host_idle;
      endcase
    end
  end

  // Read data and strobe come from the device's clock; sample one cycle after the edge
  always_ff @(posedge mclk) begin
    if (srst) begin
      dq_s1_q  <= '0;
      dq_s2_q  <= '0;
      dqs_s1_q <= 1'b0;
      dqs_s2_q <= 1'b0;
      dqs_s3_q <= 1'b0;
      edge_q   <= 1'b0;
    end else begin
      dq_s1_q  <= link.dq;
      dq_s2_q  <= dq_s1_q;
      dqs_s1_q <= link.dqs[0];
      dqs_s2_q <= dqs_s1_q;
      dqs_s3_q <= dqs_s2_q;
      edge_q   <= (dqs_s2_q != dqs_s3_q) && (state_q == lpi_pkg::host_read);
    end
  end

  assign link.link_clk        = clk_q;
  assign link.cs_n            = cmd_q[3];
  assign link.ras_n           = cmd_q[2];
  assign link.cas_n           = cmd_q[1];
  assign link.we_n            = cmd_q[0];
  assign link.bank_select     = bank_q;
  assign link.addr            = addr_q;
  assign link.byte_write_mask = mask_q;
  assign link.dq_h            = dq_q;
  assign link.dq_h_oe         = dq_oe_q;
  assign link.dqs_h           = dqs_q;
  assign link.dqs_h_oe        = dqs_oe_q;

endmodule

`default_nettype wire

//--- design/lpi_link_if.sv
// Pin-level link between memory controller and memory device
`timescale 1ns/10ps
`default_nettype none
`include "lpi_map.svh"

interface lpi_link_if;
  logic                   link_clk;
  logic                   cs_n;
  logic                   ras_n;
  logic                   cas_n;
  logic                   we_n;
  logic [1:0]             bank_select;
  logic [`LPI_ADDR_W-1:0] addr;
  logic [`LPI_LANES-1:0]  byte_write_mask;
  logic [`LPI_DQ_W-1:0]   dq_h;
  logic                   dq_h_oe;
  logic [`LPI_DQ_W-1:0]   dq_d;
  logic                   dq_d_oe;
  logic [`LPI_LANES-1:0]  dqs_h;
  logic                   dqs_h_oe;
  logic [`LPI_LANES-1:0]  dqs_d;
  logic                   dqs_d_oe;
  logic [`LPI_DQ_W-1:0]   dq;
  logic [`LPI_LANES-1:0]  dqs;

  // Resolved bus level; undriven reads low
  assign dq  = dq_d_oe ? dq_d : (dq_h_oe ? dq_h : '0);
  assign dqs = dqs_d_oe ? dqs_d : (dqs_h_oe ? dqs_h : '0);

  modport host (
    output link_clk, cs_n, ras_n, cas_n, we_n, bank_select, addr, byte_write_mask,
    output dq_h, dq_h_oe, dqs_h, dqs_h_oe,
    input  dq, dqs
  );

  modport dev (
    input  link_clk, cs_n, ras_n, cas_n, we_n, bank_select, addr, byte_write_mask,
    output dq_d, dq_d_oe, dqs_d, dqs_d_oe,
    input  dq, dqs
  );
endinterface

`default_nettype wire

//--- design/lpi_map.svh
// Constants for the low-power DDR pin interface: widths, fields, reset values, timing phases
`ifndef LPI_MAP_SVH
`define LPI_MAP_SVH

`define LPI_ADDR_W         14
`define LPI_DQ_W           32
`define LPI_LANES          4
`define LPI_LANE_W         8
`define LPI_BANKS          4
`define LPI_MEM_DEPTH      256
`define LPI_AUTO_CLOSE_BIT 10

`define LPI_BL_LSB         0
`define LPI_BL_MSB         2
`define LPI_BL_CODE_4      3'h2
`define LPI_BL_CODE_8      3'h3
`define LPI_BL_CODE_16     3'h4
`define LPI_LAST_2         4'h1
`define LPI_LAST_4         4'h3
`define LPI_LAST_8         4'h7
`define LPI_LAST_16        4'hf
`define LPI_MR_RESET       14'h0001

`define LPI_PH_RISE        2'h0
`define LPI_PH_PRE         2'h1
`define LPI_PH_SLOT        2'h2
`define LPI_PH_TOGGLE      2'h3

`define LPI_RST_HOLD       4'hf

`endif

//--- design/lpi_pkg.sv
// Types shared by both ends of the low-power DDR pin interface
`default_nettype none
`include "lpi_map.svh"

package lpi_pkg;

  // Command code {chip select, row strobe, column strobe, write enable}, all active low
  typedef enum logic [3:0] {
    cmd_lmr = 4'h0,
    cmd_ref = 4'h1,
    cmd_pre = 4'h2,
    cmd_act = 4'h3,
    cmd_wr  = 4'h4,
    cmd_rd  = 4'h5,
    cmd_bst = 4'h6,
    cmd_nop = 4'h7
  } lpi_cmd_t;

  typedef enum logic [1:0] {
    dev_idle     = 2'b00,
    dev_write    = 2'b01,
    dev_read     = 2'b10,
    dev_read_end = 2'b11
  } lpi_dev_state_t;

  typedef enum logic [1:0] {
    host_idle  = 2'b00,
    host_write = 2'b01,
    host_read  = 2'b10
  } lpi_host_state_t;

  // Index of the last beat of a burst for a burst-length code
  function automatic logic [3:0] lpi_burst_last(input logic [2:0] code);
    case (code)
      `LPI_BL_CODE_4:  lpi_burst_last = `LPI_LAST_4;
      `LPI_BL_CODE_8:  lpi_burst_last = `LPI_LAST_8;
      `LPI_BL_CODE_16: lpi_burst_last = `LPI_LAST_16;
      default:         lpi_burst_last = `LPI_LAST_2;
    endcase
  endfunction

endpackage

`default_nettype wire

//--- verif/lpddr_pin_function_interface_tb.sv
// Bench joining the controller and device ends across the pin link
`timescale 1ns/10ps
`default_nettype none
`include "lpi_map.svh"

module lpddr_pin_function_interface_tb;
  typedef struct packed {
    lpi_pkg::lpi_cmd_t cmd;
    logic [1:0]        bank;
    logic [13:0]       addr;
    logic [3:0]        open;
  } lpi_row_t;

  logic              mclk      = 1'b0;
  logic              srst      = 1'b1;
  logic              chk_rst   = 1'b1;
  logic              req_valid = 1'b0;
  logic              req_ready;
  lpi_pkg::lpi_cmd_t req_cmd   = lpi_pkg::cmd_nop;
  logic [1:0]        req_bank  = 2'h0;
  logic [13:0]       req_addr  = 14'h0000;
  logic              wr_valid  = 1'b0;
  logic              wr_ready;
  logic [31:0]       wr_data   = 32'h0000_0000;
  logic [3:0]        wr_mask   = 4'h0;
  logic              rd_valid;
  logic [31:0]       rd_data;
  logic [3:0]        bank_open;
  logic [3:0]        m;
  logic [31:0]       exp_w [8];
  int                error_cnt = 0;
  int                tests_run = 0;
  int                cycle_cnt = 0;
  int                n;
  // Command, bank, address, expected open banks; 4'hb has chip select high
  lpi_row_t          rows [9] = '{
    '{lpi_pkg::cmd_act, 2'h0, 14'h0000, 4'h1}, '{lpi_pkg::cmd_act, 2'h1, 14'h0002, 4'h3},
    '{lpi_pkg::lpi_cmd_t'(4'hb), 2'h2, 14'h0000, 4'h3}, '{lpi_pkg::cmd_pre, 2'h0, 14'h0000, 4'h2},
    '{lpi_pkg::cmd_act, 2'h3, 14'h0001, 4'ha}, '{lpi_pkg::cmd_pre, 2'h2, 14'h0400, 4'h0},
    '{lpi_pkg::cmd_act, 2'h1, 14'h0002, 4'h2}, '{lpi_pkg::cmd_lmr, 2'h0, 14'h0003, 4'h2},
    '{lpi_pkg::cmd_lmr, 2'h1, 14'h0004, 4'h2}};

  lpi_link_if link ();

  lpi_host lpi_host_inst (.mclk(mclk), .srst(srst), .req_valid(req_valid), .req_ready(req_ready),
    .req_cmd(req_cmd), .req_bank(req_bank), .req_addr(req_addr), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_data(wr_data), .wr_mask(wr_mask), .rd_valid(rd_valid), .rd_data(rd_data), .link(link));

  lpi_device lpi_device_inst (.mclk(mclk), .srst(srst), .link(link), .bank_open(bank_open));

  lpi_link_props lpi_link_props_inst (.mclk(mclk), .srst(chk_rst), .link_clk(link.link_clk), .cs_n(link.cs_n),
    .ras_n(link.ras_n), .cas_n(link.cas_n), .we_n(link.we_n), .bank_select(link.bank_select), .addr(link.addr),
    .byte_write_mask(link.byte_write_mask), .dq_h(link.dq_h), .dq_h_oe(link.dq_h_oe), .dqs_h(link.dqs_h),
    .dqs_h_oe(link.dqs_h_oe), .dq_d(link.dq_d), .dq_d_oe(link.dq_d_oe), .dqs_d(link.dqs_d),
    .dqs_d_oe(link.dqs_d_oe));

  always #50 mclk = ~mclk;

  always @(posedge mclk) begin
    cycle_cnt <= cycle_cnt + 1;
    if (cycle_cnt == 20000) begin
      error_cnt = error_cnt + 1;
      end_of_test();
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (seen !== exp) begin
      error_cnt = error_cnt + 1;
      $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic end_of_test();
    $display("Counts: %0d compares, %0d mismatches", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // One command through the request handshake
  task automatic issue(input lpi_pkg::lpi_cmd_t cmd, input logic [1:0] bank, input logic [13:0] addr);
    int k;
    k = 0;
    @(posedge mclk);
    req_cmd   <= cmd;
    req_bank  <= bank;
    req_addr  <= addr;
    req_valid <= 1'b1;
    do begin
      @(posedge mclk);
      k++;
    end while (req_ready !== 1'b1 && k < 400);
    req_valid <= 1'b0;
    check(32'(k < 400), 32'h1);
  endtask

  // Eight write beats; beat i carries base + i per byte and mask i * step
  task automatic wr_burst(input logic [31:0] base, input logic [3:0] step);
    int i;
    int k;
    i = 0;
    k = 0;
    @(posedge mclk);
    wr_valid <= 1'b1;
    wr_data  <= base;
    wr_mask  <= 4'h0;
    while (i < 8 && k < 400) begin
      @(posedge mclk);
      k++;
      if (wr_ready === 1'b1) begin
        i++;
        wr_data  <= base + 32'(i) * 32'h0101_0101;
        wr_mask  <= 4'(i) * step;
        wr_valid <= (i < 8);
      end
    end
    check(32'(i), 32'h8);
  endtask

  initial begin
    repeat (4) @(posedge mclk);
    srst <= 1'b0;
    // Device link logic leaves reset some link cycles after srst
    repeat (40) @(posedge mclk);
    chk_rst <= 1'b0;
    check(32'(bank_open), 32'h0);
    check(32'({link.cs_n, link.ras_n, link.cas_n, link.we_n}), 32'h7);
    $display("Test reset done");
    foreach (rows[r]) begin
      issue(rows[r].cmd, rows[r].bank, rows[r].addr);
      repeat (16) @(posedge mclk);
      check(32'(bank_open), 32'(rows[r].open));
    end
    check(32'(link.addr), 32'h0004);
    $display("Test command table done");
    issue(lpi_pkg::cmd_wr, 2'h1, 14'h000e);
    wr_burst(32'ha0a0_a0a0, 4'h0);
    issue(lpi_pkg::cmd_wr, 2'h1, 14'h000e);
    wr_burst(32'h5050_5050, 4'h9);
    for (int i = 0; i < 8; i++) begin
      m = 4'(i * 9);
      for (int b = 0; b < 4; b++) begin
        exp_w[i][8*b +: 8] = m[b] ? 8'(8'ha0 + i) : 8'(8'h50 + i);
      end
    end
    // Column wraps from 0xe; bit 10 closes the bank after the burst
    issue(lpi_pkg::cmd_rd, 2'h1, 14'h040e);
    n = 0;
    repeat (120) begin
      @(posedge mclk);
      if (rd_valid === 1'b1) begin
        if (n < 8) check(rd_data, exp_w[n]);
        n++;
      end
    end
    check(32'(n), 32'h8);
    check(32'(bank_open), 32'h0);
    $display("Test masked burst done");
    end_of_test();
  end
endmodule

`default_nettype wire

//--- verif/lpi_link_props.sv
// Concurrent checks on the pin link between controller and device
`timescale 1ns/10ps
`default_nettype none
`include "lpi_map.svh"

module lpi_link_props (
  // Clock and reset
  input wire logic                   mclk,
  input wire logic                   srst,
  // Command pins
  input wire logic                   link_clk,
  input wire logic                   cs_n,
  input wire logic                   ras_n,
  input wire logic                   cas_n,
  input wire logic                   we_n,
  input wire logic [1:0]             bank_select,
  input wire logic [`LPI_ADDR_W-1:0] addr,
  input wire logic [`LPI_LANES-1:0]  byte_write_mask,
  // Data and strobe drivers
  input wire logic [`LPI_DQ_W-1:0]   dq_h,
  input wire logic                   dq_h_oe,
  input wire logic [`LPI_LANES-1:0]  dqs_h,
  input wire logic                   dqs_h_oe,
  input wire logic [`LPI_DQ_W-1:0]   dq_d,
  input wire logic                   dq_d_oe,
  input wire logic [`LPI_LANES-1:0]  dqs_d,
  input wire logic                   dqs_d_oe
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  a_link_clk_shape: assert property ($rose(link_clk) |-> link_clk[*2] ##1 !link_clk[*2] ##1 link_clk)
    else $error("link clock is not a two-high two-low divide");
  a_cmd_before_rise: assert property ($changed({cs_n, ras_n, cas_n, we_n, bank_select, addr}) |->
    !link_clk ##1 !link_clk ##1 $rose(link_clk))
    else $error("command pins changed away from the setup slot");
  a_cmd_one_link: assert property ($changed({cs_n, ras_n, cas_n, we_n}) && {cs_n, ras_n, cas_n, we_n} != 4'h7
    |=> $stable({cs_n, ras_n, cas_n, we_n, bank_select, addr})[*3])
    else $error("command did not stand for a full link cycle");
  a_one_data_driver: assert property (!(dq_d_oe && dq_h_oe))
    else $error("both ends drive the data bus");
  a_dev_strobe_data: assert property (dq_d_oe == dqs_d_oe)
    else $error("device strobe enable differs from data enable");
  a_wr_strobe_centre: assert property (dqs_h_oe && $changed(dqs_h) |-> $stable(dq_h) && !link_clk
    ##1 $rose(link_clk))
    else $error("write strobe not centred in the data eye");
  a_rd_strobe_edge: assert property (dqs_d_oe && $changed(dqs_d) |-> $changed(dq_d))
    else $error("read strobe edge without a data transition");
  a_mask_with_beat: assert property ($changed(byte_write_mask) |-> $changed(dq_h))
    else $error("write mask moved without a data beat");
  a_strobe_lanes: assert property (dqs_h_oe |-> dqs_h == {`LPI_LANES{dqs_h[0]}})
    else $error("write strobe lanes disagree");
endmodule

`default_nettype wire
